// [rtl/sboie_core.sv]
// execution core for clear-accumulator, decrement/increment-and-skip,
// unconditional branch and or-literal; two-stage fetch/execute pipeline
// assumes prog_data is the word at prog_addr within the same cycle (async-read store)
// and that load_* comes from logic on sys_clk
//
// Function
// RULE1: clear accumulator zeroes it, sets null flag
// RULE2: decrement-and-skip subtracts one from file 0..127
// RULE3: target bit 0 to accumulator, 1 to file
// RULE4: decrement zero result skips next, two cycles
// RULE5: increment-and-skip adds one, routed by target bit
// RULE6: increment zero result skips next, two cycles
// RULE7: branch loads 11-bit immediate into pc 10:0
// RULE8: pc 12:11 from upper-jump latch bits 4:3
// RULE9: branch takes two cycles, flags unchanged
// RULE10: or-literal ors accumulator with 8-bit literal
// RULE11: or-literal result to accumulator, updates null flag
// RULE12: skip instructions never touch the status flags
// RULE13: skip discards fetched word, issues no-operation cycle
`timescale 1ns/1ps

module sboie_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  output logic [sboie_pkg::PC_W-1:0] prog_addr,
  input wire logic [sboie_pkg::INSTR_W-1:0] prog_data,
  input wire logic load_en,
  input wire logic [sboie_pkg::FADDR_W-1:0] load_addr,
  input wire logic [sboie_pkg::DATA_W-1:0] load_data,
  output logic [sboie_pkg::DATA_W-1:0] acc_value,
  output logic null_flag,
  output logic skip_flush,
  output logic wr_strobe,
  output logic [sboie_pkg::FADDR_W-1:0] wr_addr,
  output logic [sboie_pkg::DATA_W-1:0] wr_data
);

  // decode the top bits of a word into one operation
  function automatic sboie_pkg::sboie_op_t op_decode(input logic [13:0] word);
    sboie_pkg::sboie_op_t op;
    op = sboie_pkg::OP_NOP;
    if (word[13:7] == sboie_pkg::CLRA_TOP) begin
      op = sboie_pkg::OP_CLRA;
    end else if (word[13:8] == sboie_pkg::DECS_TOP) begin
      op = sboie_pkg::OP_DECS;
    end else if (word[13:8] == sboie_pkg::INCS_TOP) begin
      op = sboie_pkg::OP_INCS;
    end else if (word[13:8] == sboie_pkg::ORL_TOP) begin
      op = sboie_pkg::OP_ORL;
    end else if (word[13:11] == sboie_pkg::BRANCH_TOP) begin
      op = sboie_pkg::OP_BRANCH;
    end
    return op;
  endfunction : op_decode

  // file registers; data is not reset, software preloads what it needs
  logic [7:0] file_mem [sboie_pkg::FILE_DEPTH];

  logic [12:0] pc;
  logic [13:0] instr;
  logic [7:0] acc;
  logic null_q;
  sboie_pkg::sboie_state_t state;
  logic wr_strobe_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;
  // low through the release edge, so checks wait for the first real cycle
  logic chk_live;

  logic [12:0] next_pc;
  logic [13:0] next_instr;
  logic [7:0] next_acc;
  logic next_null;
  sboie_pkg::sboie_state_t next_state;
  logic next_wr_strobe;
  logic [6:0] next_wr_addr;
  logic [7:0] next_wr_data;

  // helper terms, also watched by the checks below
  sboie_pkg::sboie_op_t op;
  logic [6:0] faddr;
  logic [7:0] fval;
  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic [7:0] skip_res;
  logic [7:0] or_res;
  logic [7:0] upper_latch;
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_data;

  // operand fetch and arithmetic for the skip, or-literal and branch instructions
  always_comb begin
    op = (state == sboie_pkg::ST_FLUSH) ? sboie_pkg::OP_NOP : op_decode(instr);
    faddr = instr[6:0];                                 // RULE2
    fval = file_mem[faddr];
    dec_res = fval - 8'h01;                             // RULE2
    inc_res = fval + 8'h01;                             // RULE5
    skip_res = (op == sboie_pkg::OP_DECS) ? dec_res : inc_res;
    or_res = acc | instr[7:0];                          // RULE10
    upper_latch = file_mem[sboie_pkg::UPPER_LATCH_ADDR];
  end

  // next-state logic for the whole pipeline
  always_comb begin
    next_pc = pc + 13'h0001;
    next_instr = prog_data;
    next_acc = acc;
    next_null = null_q;                                 // RULE12
    next_state = sboie_pkg::ST_EXEC;
    next_wr_strobe = 1'b0;
    next_wr_addr = wr_addr_q;
    next_wr_data = wr_data_q;
    case (op)
      sboie_pkg::OP_CLRA: begin
        next_acc = 8'h00;                               // RULE1
        next_null = 1'b1;                               // RULE1
      end
      sboie_pkg::OP_DECS, sboie_pkg::OP_INCS: begin
        if (instr[sboie_pkg::DEST_BIT] == sboie_pkg::DEST_ACC) begin
          next_acc = skip_res;                          // RULE3
        end else begin
          next_wr_strobe = 1'b1;                        // RULE3
          next_wr_addr = faddr;
          next_wr_data = skip_res;
        end
        // zero result: the word fetched this cycle is dropped
        if (skip_res == 8'h00) begin
          next_state = sboie_pkg::ST_FLUSH;             // RULE4 RULE6 RULE13
        end
      end
      sboie_pkg::OP_BRANCH: begin
        next_pc = {upper_latch[sboie_pkg::LATCH_HI:sboie_pkg::LATCH_LO],
                   instr[sboie_pkg::BR_W-1:0]};         // RULE7 RULE8
        next_state = sboie_pkg::ST_FLUSH;               // RULE9
      end
      sboie_pkg::OP_ORL: begin
        next_acc = or_res;                              // RULE11
        next_null = (or_res == 8'h00);                  // RULE11
      end
      default: begin
        next_acc = acc;
      end
    endcase
  end

  // file write port: core write-back wins over a preload in the same cycle
  always_comb begin
    mem_we = next_wr_strobe | load_en;
    mem_addr = next_wr_strobe ? next_wr_addr : load_addr;
    mem_data = next_wr_strobe ? next_wr_data : load_data;
  end

  // pipeline and flag registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pc <= sboie_pkg::PC_RST;
      instr <= sboie_pkg::INSTR_RST;
      acc <= sboie_pkg::ACC_RST;
      null_q <= sboie_pkg::NULL_RST;
      state <= sboie_pkg::ST_FLUSH;                     // first held word is not yet fetched
      wr_strobe_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
      chk_live <= 1'b0;
    end else begin
      pc <= next_pc;
      instr <= next_instr;
      acc <= next_acc;
      null_q <= next_null;
      state <= next_state;
      wr_strobe_q <= next_wr_strobe;
      wr_addr_q <= next_wr_addr;
      wr_data_q <= next_wr_data;
      chk_live <= 1'b1;
    end
  end

  // file register array, no reset
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_data;
    end
  end

  // outputs straight from flops
  assign prog_addr = pc;
  assign acc_value = acc;
  assign null_flag = null_q;
  assign skip_flush = (state == sboie_pkg::ST_FLUSH);
  assign wr_strobe = wr_strobe_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  // the pin alone is not enough: on the release edge it already reads high
  // while the core still takes its reset values
  default disable iff (!rst_b || !chk_live);

  // decoded views of the held word, shared by the checks
  logic is_decs;
  logic is_incs;
  logic is_skip_op;
  logic to_acc;
  assign is_decs = (op == sboie_pkg::OP_DECS);
  assign is_incs = (op == sboie_pkg::OP_INCS);
  assign is_skip_op = is_decs | is_incs;
  assign to_acc = (instr[sboie_pkg::DEST_BIT] == sboie_pkg::DEST_ACC);

  sequence seq_branch_exec;
    op == sboie_pkg::OP_BRANCH;
  endsequence

  // a discarded cycle followed by the first fetched word at the new address
  sequence seq_two_cycle_end;
    skip_flush ##1 !skip_flush;
  endsequence

  // the counter moved on by exactly one word since the last edge
  sequence seq_step_on;
    prog_addr == $past(prog_addr) + 13'h0001;
  endsequence

  AST_CLRA: assert property (op == sboie_pkg::OP_CLRA |=> acc_value == 8'h00 && null_flag) // RULE1
    else $error("clear accumulator did not zero it and set null");

  AST_DECS_ACC: assert property (is_decs && to_acc |=> acc_value == $past(fval) - 8'h01) // RULE2
    else $error("decrement result wrong in accumulator");

  AST_DECS_FILE: assert property (is_decs && !to_acc |=> // RULE2
    wr_data == $past(fval) - 8'h01)
    else $error("decrement result wrong in file write");

  AST_DEST_FILE: assert property (is_skip_op && !to_acc |=> // RULE3
    wr_strobe && wr_addr == $past(faddr) && wr_data == $past(skip_res)
    && acc_value == $past(acc_value))
    else $error("file destination not honoured");

  AST_ACC_NO_WR: assert property (is_skip_op && to_acc |=> !wr_strobe) // RULE3
    else $error("accumulator destination also wrote the file");

  AST_DECS_SKIP: assert property (is_decs |=> skip_flush == ($past(dec_res) == 8'h00)) // RULE4
    else $error("decrement skip decision wrong");

  AST_DECS_TWO: assert property (is_decs && dec_res == 8'h00 |=> seq_two_cycle_end) // RULE4
    else $error("decrement zero did not skip exactly one word");

  AST_INCS_ACC: assert property (is_incs && to_acc |=> acc_value == $past(fval) + 8'h01) // RULE5
    else $error("increment result wrong in accumulator");

  AST_INCS_FILE: assert property (is_incs && !to_acc |=> // RULE5
    wr_data == $past(fval) + 8'h01)
    else $error("increment result wrong in file write");

  AST_INCS_SKIP: assert property (is_incs && inc_res == 8'h00 |=> seq_two_cycle_end) // RULE6
    else $error("increment zero did not skip exactly one word");

  AST_SKIP_GO: assert property (is_skip_op && skip_res != 8'h00 |=> // RULE4 RULE6
    !skip_flush && prog_addr == $past(prog_addr) + 13'h0001)
    else $error("non-zero skip result still dropped a word");

  // the dropped word is not fetched again: the counter keeps stepping by one
  AST_SKIP_DROP: assert property (is_skip_op && skip_res == 8'h00 |=> // RULE13
    seq_step_on ##1 seq_step_on)
    else $error("skip refetched or jumped instead of dropping one word");

  // target is built from the held word and the latch as they stood
  AST_BR_LOW: assert property (seq_branch_exec |=> // RULE7
    prog_addr[10:0] == $past(instr[10:0]))
    else $error("branch low address wrong");

  AST_BR_HIGH: assert property (seq_branch_exec |=> // RULE8
    prog_addr[12:11] == $past(upper_latch[4:3]))
    else $error("branch high address not from upper latch");

  AST_BR_TWO: assert property (seq_branch_exec |=> seq_two_cycle_end // RULE9
    and $stable(null_flag))
    else $error("branch not two cycles or flags moved");

  AST_BR_QUIET: assert property (seq_branch_exec |=> !wr_strobe && $stable(acc_value)) // RULE9
    else $error("branch disturbed accumulator or file");

  AST_ORL: assert property (op == sboie_pkg::OP_ORL |=> // RULE10
    acc_value == ($past(acc_value) | $past(instr[7:0])))
    else $error("or literal result wrong");

  AST_ORL_NULL: assert property (op == sboie_pkg::OP_ORL |=> // RULE11
    null_flag == (acc_value == 8'h00))
    else $error("or literal null flag wrong");

  AST_ORL_NOWR: assert property (op == sboie_pkg::OP_ORL |=> !wr_strobe) // RULE11
    else $error("or literal wrote a file register");

  AST_SKIP_FLAGS: assert property (is_skip_op |=> $stable(null_flag)) // RULE12
    else $error("skip instruction changed null flag");

  // a discarded word must leave no trace but the counter step
  AST_FLUSH_NOP: assert property (skip_flush |=> // RULE13
    $stable(acc_value) && $stable(null_flag) && !wr_strobe
    && prog_addr == $past(prog_addr) + 13'h0001)
    else $error("discarded word had an effect");

endmodule : sboie_core

// [rtl/sboie_pkg.sv]
// package for the skip, branch and literal-or execution core
// assumes one core clock and 14-bit instruction words from an outside program store
package sboie_pkg;

  // widths of the core datapaths
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int BR_W = 11;
  localparam int FILE_DEPTH = 128;

  // opcode field patterns, compared against the top bits of the word
  localparam logic [6:0] CLRA_TOP = 7'h02;
  localparam logic [5:0] DECS_TOP = 6'h0B;
  localparam logic [5:0] INCS_TOP = 6'h0F;
  localparam logic [5:0] ORL_TOP = 6'h38;
  localparam logic [2:0] BRANCH_TOP = 3'h5;

  // field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // upper-jump latch lives in the file registers
  localparam logic [6:0] UPPER_LATCH_ADDR = 7'h0A;
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic NULL_RST = 1'b0;
  localparam logic [13:0] INSTR_RST = 14'h0000;

  // operations this core carries out; anything else runs as a no-operation
  typedef enum {
    OP_NOP,
    OP_CLRA,
    OP_DECS,
    OP_INCS,
    OP_BRANCH,
    OP_ORL
  } sboie_op_t;

  // pipeline stage state: the held word is executed or thrown away
  typedef enum {
    ST_EXEC,
    ST_FLUSH
  } sboie_state_t;

endpackage : sboie_pkg

// [sim/skip_branch_or_instr_exec_bench.sv]
// self-checking bench for the skip, branch and literal-or execution core
// assumes an async-read program store modelled here; file registers preloaded after reset
`timescale 1ns/1ps

module skip_branch_or_instr_exec_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic load_en = 1'b0;
  logic [6:0] load_addr = 7'h00;
  logic [7:0] load_data = 8'h00;
  logic [7:0] acc_value;
  logic null_flag;
  logic skip_flush;
  logic wr_strobe;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [13:0] mem [0:8191];
  int cyc = 0;
  int err_total = 0;
  int n_tests = 0;

  sboie_core sboie_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .prog_addr(prog_addr),
    .prog_data(prog_data), .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .acc_value(acc_value), .null_flag(null_flag), .skip_flush(skip_flush),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));

  // store answers in the same cycle, as the core expects
  assign prog_data = mem[prog_addr];

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // edges since reset release; word n shows its effects at count n+2
  always @(posedge sys_clk) begin
    cyc <= rst_b ? cyc + 1 : 0;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // bounded wait; sampling 1 ns after the edge keeps clear of update races
  task automatic wait_to(input int t);
    int n;
    n = 0;
    while (cyc < t) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 200) begin
        chk("wait bound", 16'h0000, 16'h0001);
        print_verdict();
      end
    end
  endtask : wait_to

  task automatic st(input logic [7:0] a, input logic z, input logic s);
    chk("acc_value", {8'h00, a}, {8'h00, acc_value});
    chk("null_flag", {15'h0000, z}, {15'h0000, null_flag});
    chk("skip_flush", {15'h0000, s}, {15'h0000, skip_flush});
  endtask : st

  task automatic wr(input logic s, input logic [6:0] a, input logic [7:0] d);
    chk("wr_strobe", {15'h0000, s}, {15'h0000, wr_strobe});
    if (s) chk("wr_addr and wr_data", {1'b0, a, d}, {1'b0, wr_addr, wr_data});
  endtask : wr

  // words 0..3 stay no-ops while two file registers are preloaded
  task automatic start(input logic [6:0] a0, input logic [7:0] d0,
                       input logic [6:0] a1, input logic [7:0] d1);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    load_en <= 1'b1;
    load_addr <= a0;
    load_data <= d0;
    @(posedge sys_clk);
    load_addr <= a1;
    load_data <= d1;
    @(posedge sys_clk);
    load_en <= 1'b0;
  endtask : start

  task automatic load_prog(input logic [13:0] p [0:5]);
    foreach (mem[i]) mem[i] = 14'h0000;
    for (int i = 0; i < 6; i++) mem[4 + i] = p[i];
  endtask : load_prog

  task automatic s_or_clear();
    logic [8:0] e [0:4];
    e = '{9'h05A, 9'h0DB, 9'h100, 9'h100, 9'h080};
    load_prog('{14'h385A, 14'h3881, 14'h0100, 14'h3800, 14'h3880, 14'h0000});
    start(7'h30, 8'h11, 7'h31, 8'h22);
    for (int i = 0; i < 5; i++) begin
      wait_to(6 + i);
      st(e[i][7:0], e[i][8], 1'b0);
    end
  endtask : s_or_clear

  // not-taken decrement to file, then taken decrement to accumulator
  task automatic s_dec_skip();
    load_prog('{14'h0100, 14'h0BA0, 14'h3810, 14'h0B21, 14'h3844, 14'h3802});
    start(7'h20, 8'h02, 7'h21, 8'h01);
    wait_to(7);
    st(8'h00, 1'b1, 1'b0);
    wr(1'b1, 7'h20, 8'h01);
    wait_to(8);
    st(8'h10, 1'b0, 1'b0);
    wait_to(9);
    st(8'h00, 1'b0, 1'b1);
    wr(1'b0, 7'h00, 8'h00);
    wait_to(10);
    st(8'h00, 1'b0, 1'b0);
    wait_to(11);
    st(8'h02, 1'b0, 1'b0);
  endtask : s_dec_skip

  // wrap from FF to zero written back, then read back through the accumulator
  task automatic s_inc_skip();
    load_prog('{14'h0100, 14'h0F06, 14'h0F85, 14'h3801, 14'h3880, 14'h0F05});
    start(7'h05, 8'hFF, 7'h06, 8'h7E);
    wait_to(7);
    st(8'h7F, 1'b1, 1'b0);
    wait_to(8);
    st(8'h7F, 1'b1, 1'b1);
    wr(1'b1, 7'h05, 8'h00);
    wait_to(9);
    st(8'h7F, 1'b1, 1'b0);
    wait_to(10);
    st(8'hFF, 1'b0, 1'b0);
    wait_to(11);
    st(8'h01, 1'b0, 1'b0);
  endtask : s_inc_skip

  // latch 0xF7: only bits 4:3 (binary 10) may reach the counter top
  task automatic s_branch();
    load_prog('{14'h0100, 14'h2923, 14'h3840, 14'h3804, 14'h0000, 14'h0000});
    mem[13'h1123] = 14'h3802;
    start(7'h0A, 8'hF7, 7'h40, 8'h00);
    wait_to(7);
    chk("prog_addr", {3'h0, 13'h1123}, {3'h0, prog_addr});
    st(8'h00, 1'b1, 1'b1);
    wait_to(8);
    st(8'h00, 1'b1, 1'b0);
    wait_to(9);
    st(8'h02, 1'b0, 1'b0);
    chk("prog_addr", {3'h0, 13'h1125}, {3'h0, prog_addr});
  endtask : s_branch

  initial begin
    repeat (5000) @(posedge sys_clk);
    chk("run length bound", 16'h0000, 16'h0001);
    print_verdict();
  end

  initial begin
    s_or_clear();
    s_dec_skip();
    s_inc_skip();
    s_branch();
    print_verdict();
  end
endmodule : skip_branch_or_instr_exec_bench
